/* mpuac_attr_dec.sv */
// Purpose: decode region memory type, shareability and cache policy
// Assumes: purely combinational, used by the checker top
// Notes: reserved encodings are flagged so the checker can fault them
`timescale 1ns/10ps
`default_nettype none
module mpuac_attr_dec (
  // region fields
  input wire mpuac_pkg::mpuac_region_t region_i,
  // decoded result
  output mpuac_pkg::mpuac_attr_t attr_o,
  output logic resv_o
);
  logic [2:0] mtx;
  logic [1:0] cb;
  assign mtx = region_i.memory_type_extension_field;
  assign cb = {region_i.cacheable, region_i.bufferable};

  always_comb begin
    attr_o = '{mpuac_pkg::MT_RESV, 1'b0, mpuac_pkg::POL_NC, mpuac_pkg::POL_NC};
    resv_o = 1'b0;
    if (mtx[2]) begin
      attr_o.mtype = mpuac_pkg::MT_NORMAL; // [R5]
      attr_o.shared = region_i.shareable;
      attr_o.outer = mpuac_pkg::mpuac_pol_t'(mtx[1:0]); // [R6]
      attr_o.inner = mpuac_pkg::mpuac_pol_t'(cb); // [R6]
    end else if (mtx == mpuac_pkg::MTX_BASE) begin
      // shareable bit deliberately unused for the two ordered types
      if (cb == 2'h0) begin
        attr_o.mtype = mpuac_pkg::MT_STRONG; // [R2] [R3]
        attr_o.shared = 1'b1;
      end else if (cb == 2'h1) begin
        attr_o.mtype = mpuac_pkg::MT_DEVICE; // [R2] [R3]
        attr_o.shared = 1'b1;
      end else begin
        attr_o.mtype = mpuac_pkg::MT_NORMAL;
        attr_o.shared = region_i.shareable;
        attr_o.outer = (cb == 2'h2) ? mpuac_pkg::POL_WT : mpuac_pkg::POL_WBNA;
        attr_o.inner = attr_o.outer;
      end
    end else if (mtx == mpuac_pkg::MTX_NORM && (cb == 2'h0 || cb == 2'h3)) begin
      attr_o.mtype = mpuac_pkg::MT_NORMAL; // [R4]
      attr_o.shared = region_i.shareable;
      attr_o.outer = (cb == 2'h3) ? mpuac_pkg::POL_WBWA : mpuac_pkg::POL_NC;
      attr_o.inner = attr_o.outer;
    end else if (mtx == mpuac_pkg::MTX_NSDEV && cb == 2'h0) begin
      attr_o.mtype = mpuac_pkg::MT_DEVICE; // [R3]
    end else begin
      resv_o = 1'b1; // [R20]
    end
  end
endmodule // mpuac_attr_dec
`default_nettype wire

/* mpuac_check.sv */
// Purpose: attribute decode and permission check of one access against matched regions
// Assumes: region matching is done outside; hits and fields arrive with the request
// Notes: verdict is registered, so grant and fault appear one cycle after the request
//
// Contract
// [R1] fault any access whose permission code denies that type at that privilege
// [R2] type 000 with cb 00 is strongly ordered shared, cb 01 shared device
// [R3] where shareable is don't-care the decoder ignores it
// [R4] type 001 with cb 11 is normal write-back allocate, shareable from bit
// [R5] type with top bit set is cached normal, outer low bits, inner cb
// [R6] policy code 00 none, 01 wb alloc, 10 wt, 11 wb no alloc
// [R7] decoded cache and share attributes are reported only, never change behaviour
// [R8] permission 000 faults every access
// [R9] permission 001 privileged only; 011 full access
// [R10] permission 010 unprivileged read only, unprivileged write faults
// [R11] permission 101 privileged read only; writes and unprivileged accesses fault
// [R12] permission 110 and 111 read only for all; writes fault
// [R13] software programs flash, ram, external memory and peripherals as typical
// [R14] shareability and cache policy have no effect on access outcome
// [R15] a violation raises the memory management fault exception request
// [R16] a violation records its cause in the readable fault status
// [R17] overlapping regions resolve to the highest-numbered hit
// [R18] background map reachable by privileged accesses only
// [R19] verdict is formed with the request and gates it before memory
// [R20] reserved permission and memory type encodings fault
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module mpuac_check #(
  parameter int unsigned NREG = mpuac_pkg::NREG_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access request from the core
  input wire mpuac_pkg::mpuac_req_t req_i,
  input wire logic [NREG-1:0] region_hit_i,
  input wire mpuac_pkg::mpuac_region_t [NREG-1:0] region_cfg_i,
  // verdict toward memory and core
  output logic grant_o,
  output logic fault_o,
  output logic mm_fault_o,
  output mpuac_pkg::mpuac_attr_t attr_o,
  // register port
  input wire logic [mpuac_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mpuac_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [mpuac_pkg::DATA_W-1:0] reg_rdata_o
);
  localparam int unsigned IDXW = (NREG > 1) ? $clog2(NREG) : 1;

  if (NREG < 1 || NREG > 16) begin : g_bad_nreg
    $error("mpuac_check: NREG must be 1 to 16");
  end

  // highest-numbered hit wins on overlap
  function automatic logic [IDXW-1:0] top_hit(input logic [NREG-1:0] hits);
    top_hit = '0;
    for (int i = 0; i < NREG; i++) begin
      if (hits[i]) begin
        top_hit = IDXW'(i); // [R17]
      end
    end
  endfunction

  // registers
  logic [2:0] ctrl_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [31:0] faddr_reg;
  logic grant_reg;
  logic fault_reg;
  logic mm_fault_reg;
  mpuac_pkg::mpuac_attr_t attr_reg;
  logic [mpuac_pkg::DATA_W-1:0] rdata_reg;

  // selection and decode
  logic en;
  logic bg_en;
  logic any_hit;
  logic [IDXW-1:0] sel_idx;
  mpuac_pkg::mpuac_region_t sel;
  mpuac_pkg::mpuac_attr_t dec_attr;
  logic dec_resv;
  logic perm_ok;
  logic fault_cmb;
  mpuac_pkg::mpuac_attr_t attr_cmb;

  assign en = ctrl_reg[mpuac_pkg::CTRL_EN_BIT];
  assign bg_en = ctrl_reg[mpuac_pkg::CTRL_BG_BIT];
  assign any_hit = |region_hit_i;
  assign sel_idx = top_hit(region_hit_i);
  assign sel = region_cfg_i[sel_idx]; // [R17]

  mpuac_attr_dec u_attr (
    .region_i(sel),
    .attr_o(dec_attr),
    .resv_o(dec_resv)
  );

  mpuac_perm_dec u_perm (
    .perm_i(sel.access_permission_field),
    .priv_i(req_i.priv),
    .write_i(req_i.write),
    .allow_o(perm_ok)
  );

  // verdict is formed in the request cycle; attributes do not enter it
  always_comb begin
    fault_cmb = 1'b0;
    attr_cmb = mpuac_pkg::ATTR_DEFAULT;
    if (!en) begin
      fault_cmb = 1'b0;
    end else if (any_hit) begin
      attr_cmb = dec_attr;
      fault_cmb = ~perm_ok | dec_resv | (req_i.fetch & sel.execute_never_bit); // [R1] [R14] [R19] [R20]
    end else begin
      fault_cmb = ~(bg_en & req_i.priv); // [R18]
    end
  end

  // verdict registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grant_reg <= 1'b0;
      fault_reg <= 1'b0;
      mm_fault_reg <= 1'b0;
    end else begin
      grant_reg <= req_i.valid & ~fault_cmb; // [R19]
      fault_reg <= req_i.valid & fault_cmb; // [R1]
      mm_fault_reg <= req_i.valid & fault_cmb; // [R15]
    end
  end

  // reported attributes; informational only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attr_reg <= mpuac_pkg::ATTR_DEFAULT;
    end else if (req_i.valid) begin
      attr_reg <= attr_cmb; // [R7]
    end
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= mpuac_pkg::CTRL_RST;
    end else if (reg_we_i && reg_addr_i == mpuac_pkg::OFF_CTRL) begin
      ctrl_reg <= reg_wdata_i[2:0];
    end
  end

  // fault status: write one to clear, a new fault wins over the clear
  always_comb begin
    stat_next = stat_reg;
    if (reg_we_i && reg_addr_i == mpuac_pkg::OFF_STAT) begin
      stat_next = stat_reg & ~reg_wdata_i[7:0];
    end
    if (req_i.valid && fault_cmb) begin
      if (req_i.fetch) begin
        stat_next[mpuac_pkg::STAT_IACC_BIT] = 1'b1; // [R16]
      end else begin
        stat_next[mpuac_pkg::STAT_DACC_BIT] = 1'b1; // [R16]
        stat_next[mpuac_pkg::STAT_ADDRV_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= mpuac_pkg::STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // faulting data address; a fetch address is not captured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      faddr_reg <= mpuac_pkg::FADDR_RST;
    end else if (req_i.valid && fault_cmb && !req_i.fetch) begin
      faddr_reg <= req_i.addr; // [R16]
    end else if (reg_we_i && reg_addr_i == mpuac_pkg::OFF_FADDR) begin
      faddr_reg <= reg_wdata_i;
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (reg_re_i) begin
      if (reg_addr_i == mpuac_pkg::OFF_CTRL) begin
        rdata_reg <= {29'h0000_0000, ctrl_reg};
      end else if (reg_addr_i == mpuac_pkg::OFF_STAT) begin
        rdata_reg <= {24'h00_0000, stat_reg};
      end else if (reg_addr_i == mpuac_pkg::OFF_FADDR) begin
        rdata_reg <= faddr_reg;
      end else if (reg_addr_i == mpuac_pkg::OFF_ATTR) begin
        rdata_reg <= {23'h00_0000, attr_reg};
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  assign grant_o = grant_reg;
  assign fault_o = fault_reg;
  assign mm_fault_o = mm_fault_reg;
  assign attr_o = attr_reg;
  assign reg_rdata_o = rdata_reg;

  // checks
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [2:0] perm_s;
  logic [2:0] mtx_s;
  logic [1:0] olo_s;
  logic [1:0] cb_s;
  logic shr_s;
  logic chk_hit;
  logic xn_fetch;
  assign perm_s = sel.access_permission_field;
  assign mtx_s = sel.memory_type_extension_field;
  assign olo_s = mtx_s[1:0];
  assign cb_s = {sel.cacheable, sel.bufferable};
  assign shr_s = sel.shareable;
  assign chk_hit = req_i.valid && en && any_hit && !dec_resv;
  assign xn_fetch = req_i.fetch && sel.execute_never_bit;

  sequence data_fault_s;
    req_i.valid && en && fault_cmb && !req_i.fetch;
  endsequence

  sequence fault_seen_s;
    fault_reg && mm_fault_o && !grant_o;
  endsequence

  sequence stat_read_s;
    reg_re_i && reg_addr_i == mpuac_pkg::OFF_STAT;
  endsequence

  verdict_excl_a: assert property ( // [R19]
    !(grant_o && fault_o)
  ) else $error("grant and fault together");

  verdict_timing_a: assert property ( // [R19]
    req_i.valid |=> (grant_o ^ fault_o)
  ) else $error("request without exactly one verdict");

  idle_quiet_a: assert property ( // [R19]
    !req_i.valid |=> !grant_o && !fault_o && !mm_fault_o
  ) else $error("verdict without request");

  perm_none_a: assert property ( // [R8]
    chk_hit && perm_s == mpuac_pkg::PERM_NONE |=> fault_seen_s
  ) else $error("no-access region did not fault");

  perm_privonly_a: assert property ( // [R9]
    chk_hit && perm_s == mpuac_pkg::PERM_PRIV_RW && !req_i.priv |=> fault_o
  ) else $error("unprivileged access to privileged region passed");

  perm_full_a: assert property ( // [R9]
    chk_hit && perm_s == mpuac_pkg::PERM_FULL && !(req_i.fetch && sel.execute_never_bit) |=> grant_o
  ) else $error("full-access region refused");

  perm_uwrite_a: assert property ( // [R10]
    chk_hit && perm_s == mpuac_pkg::PERM_USER_RO && !req_i.priv |=> fault_o == $past(req_i.write)
  ) else $error("unprivileged access to user read-only region wrong");

  perm_privro_a: assert property ( // [R11]
    chk_hit && perm_s == mpuac_pkg::PERM_PRIV_RO && (req_i.write || !req_i.priv) |=> fault_o
  ) else $error("privileged read-only region passed a forbidden access");

  perm_readonly_a: assert property ( // [R12]
    chk_hit && perm_s[2:1] == 2'h3 && req_i.write |=> fault_o
  ) else $error("write to read-only region passed");

  resv_fault_a: assert property ( // [R20]
    req_i.valid && en && any_hit && (dec_resv || perm_s == mpuac_pkg::PERM_RESV) |=> fault_seen_s
  ) else $error("reserved encoding did not fault");

  background_a: assert property ( // [R18]
    req_i.valid && en && !any_hit |=> fault_o == !($past(req_i.priv) && $past(bg_en))
  ) else $error("background region privilege wrong");

  top_region_a: assert property ( // [R17]
    req_i.valid && en && region_hit_i[NREG-1] |-> sel_idx == IDXW'(NREG - 1)
  ) else $error("highest region not selected");

  strong_dec_a: assert property ( // [R2]
    chk_hit && sel.memory_type_extension_field == mpuac_pkg::MTX_BASE && !sel.cacheable && !sel.bufferable
    |=> attr_o.mtype == mpuac_pkg::MT_STRONG && attr_o.shared
  ) else $error("strongly ordered decode wrong");

  status_rec_a: assert property ( // [R16]
    data_fault_s |=> fault_seen_s ##0 stat_reg[mpuac_pkg::STAT_DACC_BIT] && stat_reg[mpuac_pkg::STAT_ADDRV_BIT]
    ##0 faddr_reg == $past(req_i.addr)
  ) else $error("data fault cause not recorded");

  status_read_a: assert property ( // [R16]
    stat_read_s ##1 !reg_re_i |-> reg_rdata_o == {24'h00_0000, $past(stat_reg)}
  ) else $error("status read data wrong");

  perm_privrw_a: assert property ( // [R9]
    chk_hit && perm_s == mpuac_pkg::PERM_PRIV_RW && req_i.priv && !xn_fetch |=> grant_o
  ) else $error("privileged access to privileged region refused");

  perm_uread_a: assert property ( // [R10]
    chk_hit && perm_s == mpuac_pkg::PERM_USER_RO && (req_i.priv || !req_i.write) && !xn_fetch |=> grant_o
  ) else $error("allowed access to user read-only region refused");

  ro_read_a: assert property ( // [R12]
    chk_hit && perm_s[2:1] == 2'h3 && !req_i.write && !xn_fetch |=> grant_o
  ) else $error("read of read-only region refused");

  xn_fetch_a: assert property ( // [R1]
    req_i.valid && en && any_hit && xn_fetch |=> fault_seen_s
  ) else $error("fetch from execute-never region passed");

  fetch_status_a: assert property ( // [R16]
    req_i.valid && en && fault_cmb && req_i.fetch |=> stat_reg[mpuac_pkg::STAT_IACC_BIT]
  ) else $error("fetch fault cause not recorded");

  disabled_pass_a: assert property ( // [R19]
    req_i.valid && !en |=> grant_o && attr_o == mpuac_pkg::ATTR_DEFAULT
  ) else $error("disabled checker did not pass access");

  bg_attr_a: assert property ( // [R18]
    req_i.valid && en && !any_hit |=> attr_o == mpuac_pkg::ATTR_DEFAULT
  ) else $error("background attributes wrong");

  attr_hold_a: assert property ( // [R7]
    !req_i.valid |=> $stable(attr_o)
  ) else $error("attributes changed without request");

  device_dec_a: assert property ( // [R2]
    chk_hit && mtx_s == mpuac_pkg::MTX_BASE && cb_s == 2'h1
    |=> attr_o.mtype == mpuac_pkg::MT_DEVICE && attr_o.shared
  ) else $error("shared device decode wrong");

  nsdev_dec_a: assert property ( // [R3]
    chk_hit && mtx_s == mpuac_pkg::MTX_NSDEV |=> attr_o.mtype == mpuac_pkg::MT_DEVICE && !attr_o.shared
  ) else $error("non-shared device decode wrong");

  wbwa_dec_a: assert property ( // [R4]
    chk_hit && mtx_s == mpuac_pkg::MTX_NORM && cb_s == 2'h3
    |=> attr_o.outer == mpuac_pkg::POL_WBWA && attr_o.inner == mpuac_pkg::POL_WBWA && attr_o.shared == $past(shr_s)
  ) else $error("write-back allocate decode wrong");

  cached_dec_a: assert property ( // [R5] [R6]
    chk_hit && mtx_s[2] |=> attr_o.mtype == mpuac_pkg::MT_NORMAL && attr_o.shared == $past(shr_s)
    && attr_o.outer == $past(olo_s) && attr_o.inner == $past(cb_s)
  ) else $error("cached normal decode wrong");
endmodule // mpuac_check
`default_nettype wire

/* mpuac_check_tb.sv */
// Purpose: self-checking bench for the attribute decode and permission check
// Assumes: eight regions, register port answers reads one cycle later
// Notes: region word is type[9:7] share[6] cache[5] buffer[4] perm[3:1] no_exec[0]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module mpuac_check_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mpuac_pkg::mpuac_req_t req;
  logic [7:0] hit;
  mpuac_pkg::mpuac_region_t [7:0] cfg = '0;
  logic grant;
  logic fault;
  logic mmf;
  mpuac_pkg::mpuac_attr_t attr;
  logic [7:0] raddr = '0;
  logic [31:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  mpuac_check #(.NREG(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .region_hit_i(hit),
    .region_cfg_i(cfg), .grant_o(grant), .fault_o(fault), .mm_fault_o(mmf), .attr_o(attr),
    .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata));
  mpuac_core_model i_core (.clk_i(clk_i), .grant_i(grant), .fault_i(fault), .mm_fault_i(mmf),
    .req_o(req), .hit_o(hit));

  always #25 clk_i = ~clk_i;

  // a hang is cut short well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    raddr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    raddr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_rd(a, d);
    `CHK(n, e, d)
  endtask

  task automatic set_all(input logic [9:0] v);
    @(posedge clk_i);
    cfg <= {8{v}};
  endtask

  // one access, exactly one of grant or fault, both pulses gone a cycle later
  task automatic acc(input logic w, input logic p, input logic f, input logic [7:0] h, input logic ef);
    i_core.access(w, p, f, 32'h2000_0010, h);
    `CHK("grant", ~ef, i_core.ans_v[2])
    `CHK("fault", ef, i_core.ans_v[1])
    `CHK("mm_fault", ef, i_core.ans_v[0])
    `CHK("pulse", 2'b00, i_core.late_v)
  endtask

  task automatic t_reset();
    logic [31:0] d;
    #1 `CHK("attr_rst", mpuac_pkg::ATTR_DEFAULT, attr)
    `CHK("verdict_rst", 3'h0, {grant, fault, mmf})
    rd_chk("ctrl", 8'h00, 32'h0000_0000);
    rd_chk("status", 8'h04, 32'h0000_0000);
    rd_chk("faddr", 8'h08, 32'h0000_0000);
    rd_chk("attr_reg", 8'h0C, 32'h0000_008A);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    reg_wr(8'h08, 32'h1234_5678);
    rd_chk("faddr_wr", 8'h08, 32'h1234_5678);
    @(posedge clk_i);
    #1 `CHK("rdata_idle", 32'h0000_0000, rdata)
    set_all(10'h000);
    acc(1'b1, 1'b0, 1'b0, 8'h01, 1'b0);
  endtask

  task automatic t_perm();
    logic [2:0] pc;
    logic al;
    reg_wr(8'h00, 32'h0000_0001);
    for (int k = 0; k < 32; k++) begin
      pc = k[4:2];
      // k[1] is privilege, k[0] is write
      case (pc)
        3'h0, 3'h4: al = 1'b0;
        3'h1: al = k[1];
        3'h2: al = k[1] | ~k[0];
        3'h3: al = 1'b1;
        3'h5: al = k[1] & ~k[0];
        default: al = ~k[0];
      endcase
      set_all({3'h0, 3'h2, pc, 1'b0});
      acc(k[0], k[1], 1'b0, 8'h01, ~al);
    end
  endtask

  // user write through full access region 7; policy only compared where it is defined
  task automatic try_attr(input logic [5:0] e, input logic ef, input mpuac_pkg::mpuac_mtype_t mt,
                          input logic sh, input logic [3:0] pl, input logic pol);
    set_all({e, mpuac_pkg::PERM_FULL, 1'b0});
    acc(1'b1, 1'b0, 1'b0, 8'h80, ef);
    `CHK("mtype", mt, attr.mtype)
    if (!ef) `CHK("shared", sh, attr.shared)
    if (pol) `CHK("policy", pl, {attr.outer, attr.inner})
  endtask

  task automatic t_attr();
    try_attr(6'b000_1_00, 1'b0, mpuac_pkg::MT_STRONG, 1'b1, 4'h0, 1'b0);
    try_attr(6'b000_0_00, 1'b0, mpuac_pkg::MT_STRONG, 1'b1, 4'h0, 1'b0);
    try_attr(6'b000_1_01, 1'b0, mpuac_pkg::MT_DEVICE, 1'b1, 4'h0, 1'b0);
    try_attr(6'b000_0_10, 1'b0, mpuac_pkg::MT_NORMAL, 1'b0, 4'hA, 1'b1);
    try_attr(6'b000_1_10, 1'b0, mpuac_pkg::MT_NORMAL, 1'b1, 4'hA, 1'b1);
    try_attr(6'b000_1_11, 1'b0, mpuac_pkg::MT_NORMAL, 1'b1, 4'hF, 1'b1);
    try_attr(6'b011_1_11, 1'b1, mpuac_pkg::MT_RESV, 1'b0, 4'h0, 1'b0);
    try_attr(6'b001_0_00, 1'b0, mpuac_pkg::MT_NORMAL, 1'b0, 4'h0, 1'b1);
    try_attr(6'b001_1_11, 1'b0, mpuac_pkg::MT_NORMAL, 1'b1, 4'h5, 1'b1);
    try_attr(6'b001_0_11, 1'b0, mpuac_pkg::MT_NORMAL, 1'b0, 4'h5, 1'b1);
    try_attr(6'b001_0_01, 1'b1, mpuac_pkg::MT_RESV, 1'b0, 4'h0, 1'b0);
    try_attr(6'b010_1_00, 1'b0, mpuac_pkg::MT_DEVICE, 1'b0, 4'h0, 1'b0);
    try_attr(6'b010_0_10, 1'b1, mpuac_pkg::MT_RESV, 1'b0, 4'h0, 1'b0);
    try_attr(6'b101_1_10, 1'b0, mpuac_pkg::MT_NORMAL, 1'b1, 4'h6, 1'b1);
    try_attr(6'b110_0_11, 1'b0, mpuac_pkg::MT_NORMAL, 1'b0, 4'hB, 1'b1);
    try_attr(6'b111_0_00, 1'b0, mpuac_pkg::MT_NORMAL, 1'b0, 4'hC, 1'b1);
  endtask

  task automatic t_prio();
    logic [31:0] d;
    reg_wr(8'h04, 32'h0000_00FF);
    @(posedge clk_i);
    cfg <= {20'h0, 10'b000_010_000_0, 20'h0, 10'b000_010_011_0, 20'h0};
    acc(1'b0, 1'b1, 1'b0, 8'h24, 1'b1);
    rd_chk("faddr_cap", 8'h08, 32'h2000_0010);
    rd_chk("status_d", 8'h04, 32'h0000_0082);
    @(posedge clk_i);
    cfg <= {20'h0, 10'b000_010_011_0, 20'h0, 10'b000_010_000_0, 20'h0};
    acc(1'b0, 1'b1, 1'b0, 8'h24, 1'b0);
    reg_wr(8'h04, 32'h0000_00FF);
    rd_chk("status_clr", 8'h04, 32'h0000_0000);
    set_all(10'b000_010_011_1);
    acc(1'b0, 1'b1, 1'b1, 8'h01, 1'b1);
    reg_rd(8'h04, d);
    `CHK("status_i", 2'b01, d[1:0])
  endtask

  task automatic t_bg();
    reg_wr(8'h00, 32'h0000_0005);
    acc(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
    `CHK("attr_bg", mpuac_pkg::ATTR_DEFAULT, attr)
    acc(1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
    reg_wr(8'h00, 32'h0000_0001);
    acc(1'b0, 1'b1, 1'b0, 8'h00, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_perm();
    t_attr();
    t_prio();
    t_bg();
    end_of_test();
  end
endmodule // mpuac_check_tb
`default_nettype wire

/* mpuac_core_model.sv */
// Purpose: behavioural core access unit issuing one access at a time to the checker
// Assumes: verdict arrives just after the edge that takes the request, one cycle after the request is driven
// Notes: idle fields carry the inverse of the last access, so stale values never look like a request
`timescale 1ns/10ps
`default_nettype none
module mpuac_core_model (
  // clock
  input wire logic clk_i,
  // verdict from the checker
  input wire logic grant_i,
  input wire logic fault_i,
  input wire logic mm_fault_i,
  // request toward the checker
  output var mpuac_pkg::mpuac_req_t req_o,
  output logic [7:0] hit_o
);
  logic [2:0] ans_v;
  logic [1:0] late_v;

  initial begin
    req_o = '0;
    hit_o = '0;
    ans_v = '0;
    late_v = '0;
  end

  // memory is only reached once grant is seen in the answer cycle
  task automatic access(input logic w, input logic p, input logic f, input logic [31:0] a, input logic [7:0] h);
    @(posedge clk_i);
    req_o <= '{1'b1, w, p, f, a};
    hit_o <= h;
    @(posedge clk_i);
    req_o <= '{1'b0, ~w, ~p, ~f, ~a};
    hit_o <= ~h;
    #1 ans_v = {grant_i, fault_i, mm_fault_i};
    @(posedge clk_i);
    #1 late_v = {grant_i, fault_i};
  endtask
endmodule // mpuac_core_model
`default_nettype wire

/* mpuac_perm_dec.sv */
// Purpose: decide whether an access type is granted by a permission code
// Assumes: purely combinational, used by the checker top
// Notes: the reserved code grants nothing
`timescale 1ns/10ps
`default_nettype none
module mpuac_perm_dec (
  // access description
  input wire logic [2:0] perm_i,
  input wire logic priv_i,
  input wire logic write_i,
  // verdict
  output logic allow_o
);
  always_comb begin
    allow_o = 1'b0;
    case (perm_i)
      mpuac_pkg::PERM_NONE: allow_o = 1'b0; // [R8]
      mpuac_pkg::PERM_PRIV_RW: allow_o = priv_i; // [R9]
      mpuac_pkg::PERM_USER_RO: allow_o = priv_i | ~write_i; // [R10]
      mpuac_pkg::PERM_FULL: allow_o = 1'b1; // [R9]
      mpuac_pkg::PERM_PRIV_RO: allow_o = priv_i & ~write_i; // [R11]
      mpuac_pkg::PERM_RO_A, mpuac_pkg::PERM_RO_B: allow_o = ~write_i; // [R12]
      default: allow_o = 1'b0; // [R20]
    endcase
  end
endmodule // mpuac_perm_dec
`default_nettype wire

/* mpuac_pkg.sv */
// Purpose: shared constants and types for the region attribute and permission checker
// Assumes: one region attribute set per access, selected from up to 16 regions
// Notes: register offsets are byte addresses on the plain register port
`default_nettype none
package mpuac_pkg;
  // sizing
  localparam int unsigned NREG_DEF = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_FADDR = 8'h08;
  localparam logic [7:0] OFF_ATTR = 8'h0C;
  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BG_BIT = 2;
  localparam int unsigned STAT_IACC_BIT = 0;
  localparam int unsigned STAT_DACC_BIT = 1;
  localparam int unsigned STAT_ADDRV_BIT = 7;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [31:0] FADDR_RST = 32'h0000_0000;
  // access permission codes
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_PRIV_RW = 3'h1;
  localparam logic [2:0] PERM_USER_RO = 3'h2;
  localparam logic [2:0] PERM_FULL = 3'h3;
  localparam logic [2:0] PERM_RESV = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO = 3'h5;
  localparam logic [2:0] PERM_RO_A = 3'h6;
  localparam logic [2:0] PERM_RO_B = 3'h7;
  // memory type extension codes
  localparam logic [2:0] MTX_BASE = 3'h0;
  localparam logic [2:0] MTX_NORM = 3'h1;
  localparam logic [2:0] MTX_NSDEV = 3'h2;

  typedef enum logic [3:0] {
    MT_STRONG = 4'h1,
    MT_DEVICE = 4'h2,
    MT_NORMAL = 4'h4,
    MT_RESV = 4'h8
  } mpuac_mtype_t;

  typedef enum logic [1:0] {
    POL_NC = 2'h0,
    POL_WBWA = 2'h1,
    POL_WT = 2'h2,
    POL_WBNA = 2'h3
  } mpuac_pol_t;

  typedef struct packed {
    logic [2:0] memory_type_extension_field;
    logic shareable;
    logic cacheable;
    logic bufferable;
    logic [2:0] access_permission_field;
    logic execute_never_bit;
  } mpuac_region_t;

  typedef struct packed {
    mpuac_mtype_t mtype;
    logic shared;
    mpuac_pol_t outer;
    mpuac_pol_t inner;
  } mpuac_attr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic fetch;
    logic [31:0] addr;
  } mpuac_req_t;

  // attributes of the background map
  localparam mpuac_attr_t ATTR_DEFAULT = '{MT_NORMAL, 1'b0, POL_WT, POL_WT};
endpackage
`default_nettype wire
